// ==== cfg_spi_chk.sv ====
// assertions on the config link joining host and device ends
// assumes a host half_cycles of 4; everything sampled on ref_clk
`timescale 1ns/1ps
module cfg_spi_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic config_serial_clock,
  input wire logic cs_n,
  input wire logic sdio_host_o,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic sdo_dev_o,
  input wire logic sdo_dev_oe,
  input wire logic config_serial_data_io,
  input wire logic sdo_line
);
  logic clk_q;
  logic [15:0] rise_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // serial clock rises per frame; counted at the pin, so ahead of the device
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_q <= 1'b0;
      rise_q <= 16'h0000;
    end
    else
    begin
      clk_q <= config_serial_clock;
      if (cs_n)
        rise_q <= 16'h0000;
      else if (config_serial_clock && !clk_q)
        rise_q <= rise_q + 16'h0001;
    end
  end

  property p_host_in_frame;
    sdio_host_oe |-> !cs_n;
  endproperty
  a_host_in_frame: assert property (p_host_in_frame)
    else $error("host drives data outside a frame");

  property p_instr_driven;
    $fell(cs_n) |-> sdio_host_oe;
  endproperty
  a_instr_driven: assert property (p_instr_driven)
    else $error("host not driving the instruction");

  property p_dev_quiet;
    cs_n [*8] |-> !sdio_dev_oe && !sdo_dev_oe;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("device drives while deselected");

  property p_turnaround;
    $rose(sdio_dev_oe) |-> rise_q >= 16'h0010 && rise_q[2:0] == 3'h0;
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("device drives before the instruction ends");

  property p_one_out;
    !(sdio_dev_oe && sdo_dev_oe);
  endproperty
  a_one_out: assert property (p_one_out)
    else $error("device drives both output lines");

  property p_cs_setup;
    $fell(cs_n) |-> !config_serial_clock [*8];
  endproperty
  a_cs_setup: assert property (p_cs_setup)
    else $error("serial clock too soon after select");

  property p_clk_high;
    $rose(config_serial_clock) |-> config_serial_clock [*4]
      ##1 !config_serial_clock;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("serial clock high time wrong");

  property p_host_stable;
    config_serial_clock && $past(config_serial_clock) && sdio_host_oe
      |-> $stable(sdio_host_o);
  endproperty
  a_host_stable: assert property (p_host_stable)
    else $error("host data moves while clock high");

  property p_frame_bytes;
    $rose(cs_n) |-> rise_q >= 16'h0018 && rise_q[2:0] == 3'h0;
  endproperty
  a_frame_bytes: assert property (p_frame_bytes)
    else $error("frame not whole instruction and bytes");
endmodule : cfg_spi_chk

// ==== cfg_spi_device.sv ====
// device end: serial register port with streaming and paired styles
// assumes serial clock well below ref_clk/6; all link pins are asynchronous
// Operation
// - style bit 0 selects streaming
// - streaming selected after reset
// - streaming: one instruction, then data bytes
// - step address up or down per direction
// - step count field bounds automatic steps
// - ascending wraps from top to zero
// - descending wraps from zero to top
// - step count clears at chip-select rise
// - retain bit keeps step count
// - streaming frame is all reads or writes
// - style bit 1 selects paired transactions
// - each paired transaction has own instruction
// - checksum byte follows each data byte
// - checksum over the data byte only
// - mismatched checksum makes access invalid
// - polynomial x^8 + x^2 + x + 1
// - checksum starts from 0xa5
// - undefined addresses are reserved
// - bits are read-only, read/write, write-one-clear
// - instruction: read bit, 15-bit address
// - msb first, sample rise, shift fall
// - write lands per byte, after valid checksum
// - paired style: one byte per instruction
`timescale 1ns/1ps
module cfg_spi_device
  import cfg_spi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial link
  cfg_spi_if.device link,
  // configuration seen by the rest of the chip
  output logic four_wire_select,
  output logic streaming_style,
  output logic checksum_error
);
  import cfg_spi_pkg::*;

  localparam int num_regs = 186;

  typedef enum {ph_instr, ph_data, ph_crc} phase_t;

  logic [2:0] sclk_s_q;
  logic [2:0] cs_s_q;
  logic [1:0] din_s_q;
  logic rise, fall, cs_fall, cs_rise;
  logic [7:0] regs_q [num_regs];
  logic [1:0] status_q;
  phase_t phase_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic rd_q;
  logic [14:0] addr_q;
  logic [14:0] start_q;
  logic [7:0] step_cnt_q;
  logic [7:0] wbyte_q;
  logic [7:0] rbyte_q;
  logic [7:0] tx_q;
  logic dout_q;
  logic oe_q;
  logic style_paired, dir_up, crc_en, keep_cnt;
  logic [7:0] step_limit;
  logic [14:0] next_addr;
  logic [7:0] next_cnt;
  logic byte_done, access_done, wr_en, crc_bad, resv_hit;
  logic [14:0] wr_addr;
  logic [7:0] wr_data;

  function automatic logic [7:0] rd_fn(input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == link_status_addr)
    begin
      v[checksum_error_pos] = status_q[checksum_error_pos];
      v[reserved_access_pos] = status_q[reserved_access_pos];
      v[style_mirror_pos] = style_paired;
    end
    else if (a <= top_addr)
      v = regs_q[a[7:0]];
    return v;
  endfunction : rd_fn

  // pins cross into ref_clk through two flops before any logic
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      din_s_q <= 2'h0;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[1:0], link.config_serial_clock};
      cs_s_q <= {cs_s_q[1:0], link.cs_n};
      din_s_q <= {din_s_q[0], link.config_serial_data_io};
    end
  end

  assign rise = sclk_s_q[1] & ~sclk_s_q[2] & ~cs_s_q[1];
  assign fall = ~sclk_s_q[1] & sclk_s_q[2] & ~cs_s_q[1];
  assign cs_fall = ~cs_s_q[1] & cs_s_q[2];
  assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
  assign sh_d = {sh_q[14:0], din_s_q[1]};

  assign style_paired =
    regs_q[setup_b_addr[7:0]][instruction_style_select_pos];
  assign dir_up = regs_q[setup_a_addr[7:0]][addr_dir_pos];
  assign crc_en = regs_q[checksum_setup_addr[7:0]][checksum_enable_pos];
  assign keep_cnt = regs_q[loop_setup_b_addr[7:0]][keep_step_count_pos];
  assign step_limit = regs_q[loop_setup_a_addr[7:0]];

  // next streaming address with wrap and step-count looping
  always_comb
  begin
    next_cnt = step_cnt_q + 8'h01;
    if (dir_up)
      next_addr = (addr_q == top_addr) ? 15'h0000 : addr_q + 15'h0001;
    else
      next_addr = (addr_q == 15'h0000) ? top_addr : addr_q - 15'h0001;
    // the step that follows the n-th one returns to the start address
    if (step_limit != 8'h00 && step_cnt_q == step_limit)
    begin
      next_addr = start_q;
      next_cnt = 8'h00;
    end
  end

  // byte boundaries, write strobe and checksum verdict
  always_comb
  begin
    byte_done = rise && phase_q != ph_instr && bit_cnt_q == 5'd7;
    access_done = byte_done && (phase_q == ph_crc || !crc_en);
    wr_addr = addr_q;
    wr_data = sh_d[7:0];
    crc_bad = 1'b0;
    wr_en = 1'b0;
    if (byte_done && !rd_q)
    begin
      if (phase_q == ph_data && !crc_en)
        wr_en = 1'b1;
      else if (phase_q == ph_crc)
      begin
        wr_data = wbyte_q;
        crc_bad = sh_d[7:0] != crc8(wbyte_q);
        wr_en = !crc_bad;
      end
    end
    resv_hit = wr_en && wr_addr > top_addr && wr_addr != link_status_addr;
  end

  // register file; a write with either soft reset bit restores defaults
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < num_regs; i++)
        regs_q[i] <= reg_reset_value;
    end
    else if (wr_en && wr_addr == setup_a_addr &&
             (wr_data[soft_reset_high_bit_pos] ||
              wr_data[soft_reset_low_bit_pos]))
    begin
      for (int i = 0; i < num_regs; i++)
        regs_q[i] <= reg_reset_value;
    end
    else
    begin
      if (wr_en && wr_addr <= top_addr)
        regs_q[wr_addr[7:0]] <= wr_data;
      if (cs_rise && !keep_cnt)
        regs_q[loop_setup_a_addr[7:0]] <= 8'h00;
    end
  end

  // sticky flags: hardware set wins over a write-one clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= 2'h0;
    else
    begin
      if (wr_en && wr_addr == link_status_addr)
        status_q <= status_q & ~wr_data[1:0];
      if (crc_bad)
        status_q[checksum_error_pos] <= 1'b1;
      if (resv_hit)
        status_q[reserved_access_pos] <= 1'b1;
    end
  end

  // frame sequencer on synchronised serial clock rising edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= ph_instr;
      bit_cnt_q <= 5'd0;
      sh_q <= 16'h0000;
      rd_q <= 1'b0;
      addr_q <= 15'h0000;
      start_q <= 15'h0000;
      step_cnt_q <= 8'h00;
      wbyte_q <= 8'h00;
      rbyte_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
    end
    else if (cs_fall || cs_rise)
    begin
      phase_q <= ph_instr;
      bit_cnt_q <= 5'd0;
      oe_q <= 1'b0;
    end
    else if (fall)
      tx_q <= {tx_q[6:0], 1'b0};
    else if (rise)
    begin
      sh_q <= sh_d;
      bit_cnt_q <= bit_cnt_q + 5'd1;
      unique case (phase_q)
        ph_instr:
        begin
          if (bit_cnt_q == 5'(instr_bits - 1))
          begin
            rd_q <= sh_d[15];
            addr_q <= sh_d[14:0];
            start_q <= sh_d[14:0];
            step_cnt_q <= 8'h00;
            phase_q <= ph_data;
            bit_cnt_q <= 5'd0;
            rbyte_q <= rd_fn(sh_d[14:0]);
            tx_q <= rd_fn(sh_d[14:0]);
            oe_q <= sh_d[15];
          end
        end
        ph_data, ph_crc:
        begin
          if (bit_cnt_q == 5'(byte_bits - 1))
          begin
            bit_cnt_q <= 5'd0;
            if (phase_q == ph_data)
              wbyte_q <= sh_d[7:0];
            if (phase_q == ph_data && crc_en)
            begin
              phase_q <= ph_crc;
              tx_q <= crc8(rbyte_q);
            end
            else if (!style_paired)
            begin
              // direction bit is read again at every step, not held for the frame
              phase_q <= ph_data;
              addr_q <= next_addr;
              step_cnt_q <= next_cnt;
              rbyte_q <= rd_fn(next_addr);
              tx_q <= rd_fn(next_addr);
            end
            else
            begin
              phase_q <= ph_instr;
              oe_q <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // shifted bit registered one cycle after the falling edge is seen
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      dout_q <= 1'b0;
    else if (fall || (rise && oe_q == 1'b0))
      dout_q <= tx_q[7];
  end

  assign four_wire_select = regs_q[setup_a_addr[7:0]][four_wire_select_pos];
  assign streaming_style = !style_paired;
  assign checksum_error = status_q[checksum_error_pos];
  assign link.sdio_dev_o = dout_q;
  assign link.sdio_dev_oe = oe_q & ~four_wire_select;
  assign link.sdo_dev_o = dout_q;
  assign link.sdo_dev_oe = oe_q & four_wire_select;
endmodule : cfg_spi_device

// ==== cfg_spi_host.sv ====
// host end: drives frames on the config link, one byte per command
// assumes user mirrors the device's style, checksum and wire settings
`timescale 1ns/1ps
module cfg_spi_host
  import cfg_spi_pkg::*;
#(
  parameter int half_cycles = sclk_half_cycles
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial link
  cfg_spi_if.host link,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [14:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_last,
  // link settings
  input wire logic streaming_style,
  input wire logic checksum_enable,
  input wire logic four_wire_select,
  // answer
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_ok
);
  import cfg_spi_pkg::*;

  typedef enum {h_idle, h_setup, h_shift, h_wait, h_hold} hstate_t;
  typedef enum {s_instr, s_data, s_crc} seg_t;

  hstate_t st_q;
  seg_t seg_q;
  logic [15:0] cnt_q;
  logic [4:0] bits_q;
  logic [15:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [7:0] wbyte_q;
  logic rd_q;
  logic last_q;
  logic cs_n_q;
  logic oe_q;
  logic [1:0] in_s_q;
  logic bit_end;

  // returning data is asynchronous to ref_clk; two flops first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      in_s_q <= 2'h3;
    else
      in_s_q <= {in_s_q[0], four_wire_select ? link.sdo_line
                                             : link.config_serial_data_io};
  end

  assign cmd_ready = st_q == h_idle || st_q == h_wait;
  assign bit_end = cnt_q == 16'(2 * half_cycles - 1);
  assign rx_d = {rx_q[6:0], in_s_q[1]};

  // sampling late in the high half leaves room for both synchronisers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= h_idle;
      seg_q <= s_instr;
      cnt_q <= 16'h0000;
      bits_q <= 5'd0;
      tx_q <= 16'h0000;
      rx_q <= 8'h00;
      wbyte_q <= 8'h00;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      cs_n_q <= 1'b1;
      oe_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_ok <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      cnt_q <= cnt_q + 16'h0001;
      unique case (st_q)
        h_idle, h_wait:
        begin
          cnt_q <= 16'h0000;
          if (cmd_valid)
          begin
            rd_q <= cmd_read;
            last_q <= cmd_last;
            wbyte_q <= cmd_wdata;
            cs_n_q <= 1'b0;
            if (st_q == h_wait && streaming_style)
            begin
              st_q <= h_shift;
              seg_q <= s_data;
              tx_q <= {cmd_wdata, 8'h00};
              bits_q <= 5'(byte_bits);
              oe_q <= !rd_q;
            end
            else
            begin
              st_q <= (st_q == h_idle) ? h_setup : h_shift;
              seg_q <= s_instr;
              tx_q <= {cmd_read, cmd_addr};
              bits_q <= 5'(instr_bits);
              oe_q <= 1'b1;
            end
          end
        end
        h_setup:
        begin
          if (cnt_q == 16'(half_cycles - 1))
          begin
            st_q <= h_shift;
            cnt_q <= 16'h0000;
          end
        end
        h_shift:
        begin
          if (bit_end)
          begin
            cnt_q <= 16'h0000;
            rx_q <= rx_d;
            tx_q <= {tx_q[14:0], 1'b0};
            bits_q <= bits_q - 5'd1;
            if (bits_q == 5'd1)
            begin
              if (seg_q == s_instr)
              begin
                seg_q <= s_data;
                tx_q <= {wbyte_q, 8'h00};
                bits_q <= 5'(byte_bits);
                oe_q <= !rd_q;
              end
              else if (seg_q == s_data && checksum_enable)
              begin
                seg_q <= s_crc;
                rsp_rdata <= rx_d;
                tx_q <= {crc8(wbyte_q), 8'h00};
                bits_q <= 5'(byte_bits);
              end
              else
              begin
                rsp_valid <= 1'b1;
                if (seg_q == s_data)
                begin
                  rsp_rdata <= rx_d;
                  rsp_ok <= 1'b1;
                end
                else
                  rsp_ok <= !rd_q || rx_d == crc8(rsp_rdata);
                oe_q <= 1'b0;
                st_q <= last_q ? h_hold : h_wait;
              end
            end
          end
        end
        h_hold:
        begin
          if (cnt_q == 16'(half_cycles - 1))
            cs_n_q <= 1'b1;
          if (cnt_q == 16'(3 * half_cycles - 1))
            st_q <= h_idle;
        end
      endcase
    end
  end

  assign link.config_serial_clock =
    st_q == h_shift && cnt_q >= 16'(half_cycles);
  assign link.cs_n = cs_n_q;
  assign link.sdio_host_o = tx_q[15];
  assign link.sdio_host_oe = oe_q & ~cs_n_q;
endmodule : cfg_spi_host

// ==== cfg_spi_if.sv ====
// serial config link between host and device ends
// resolves the shared data wire from the two output enables; idle level high
`timescale 1ns/1ps
interface cfg_spi_if;
  logic config_serial_clock;
  logic cs_n;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic sdo_dev_o;
  logic sdo_dev_oe;
  logic config_serial_data_io;
  logic sdo_line;

  assign config_serial_data_io = sdio_dev_oe ? sdio_dev_o :
    (sdio_host_oe ? sdio_host_o : 1'b1);
  assign sdo_line = sdo_dev_oe ? sdo_dev_o : 1'b1;

  modport host (
    output config_serial_clock, cs_n, sdio_host_o, sdio_host_oe,
    input config_serial_data_io, sdo_line
  );
  modport device (
    input config_serial_clock, cs_n, config_serial_data_io,
    output sdio_dev_o, sdio_dev_oe, sdo_dev_o, sdo_dev_oe
  );
endinterface : cfg_spi_if

// ==== cfg_spi_pkg.sv ====
// constants and checksum function shared by both ends of the config link
// assumes byte-wide registers behind a 15-bit serial address
package cfg_spi_pkg;
  localparam logic [14:0] setup_a_addr = 15'h0000;
  localparam logic [14:0] setup_b_addr = 15'h0001;
  localparam logic [14:0] loop_setup_a_addr = 15'h0010;
  localparam logic [14:0] loop_setup_b_addr = 15'h0011;
  localparam logic [14:0] checksum_setup_addr = 15'h0012;
  localparam logic [14:0] link_status_addr = 15'h0013;
  localparam logic [14:0] top_addr = 15'h00b9;
  localparam int soft_reset_high_bit_pos = 7;
  localparam int addr_dir_pos = 5;
  localparam int four_wire_select_pos = 4;
  localparam int soft_reset_low_bit_pos = 0;
  localparam int instruction_style_select_pos = 7;
  localparam int keep_step_count_pos = 2;
  localparam int checksum_enable_pos = 0;
  localparam int checksum_error_pos = 0;
  localparam int reserved_access_pos = 1;
  localparam int style_mirror_pos = 7;
  localparam logic [7:0] reg_reset_value = 8'h00;
  localparam logic [7:0] checksum_poly = 8'h07;
  localparam logic [7:0] checksum_init = 8'ha5;
  localparam int instr_bits = 16;
  localparam int byte_bits = 8;
  localparam int ref_period_ns = 25;
  localparam int sclk_half_ns = 100;
  localparam int sclk_half_cycles =
    (sclk_half_ns + ref_period_ns - 1) / ref_period_ns;

  // x^8 + x^2 + x + 1, msb first, no final inversion
  function automatic logic [7:0] crc8(input logic [7:0] data);
    logic [7:0] c;
    c = checksum_init;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[7] ^ data[i])
        c = {c[6:0], 1'b0} ^ checksum_poly;
      else
        c = {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
endpackage : cfg_spi_pkg

// ==== tb_config_spi_access_sequencer.sv ====
// bench: host and device ends back to back, driven from the command port
// assumes 40 MHz ref_clk and host half_cycles of 4
`timescale 1ns/1ps
module tb_config_spi_access_sequencer;
  import cfg_spi_pkg::*;
  typedef struct packed {logic rd; logic [7:0] data;} exp_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [14:0] cmd_addr = 15'h0000;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_last = 1'b0;
  logic h_stream = 1'b1;
  logic h_crc = 1'b0;
  logic h_four = 1'b0;
  logic cmd_ready, rsp_valid, rsp_ok, dev_four, dev_stream, crc_err;
  logic [7:0] rsp_rdata, d0, d1, d2, r;
  exp_t exp_q[$];
  exp_t e;
  int fails = 0;
  int samples_checked = 0;

  always #12.5 ref_clk = ~ref_clk;

  cfg_spi_if link ();
  cfg_spi_host #(.half_cycles(4)) u_cfg_spi_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_last(cmd_last),
    .streaming_style(h_stream), .checksum_enable(h_crc),
    .four_wire_select(h_four), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_ok(rsp_ok));
  cfg_spi_device u_cfg_spi_device (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .four_wire_select(dev_four), .streaming_style(dev_stream),
    .checksum_error(crc_err));
  cfg_spi_chk u_cfg_spi_chk (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .config_serial_clock(link.config_serial_clock), .cs_n(link.cs_n),
    .sdio_host_o(link.sdio_host_o), .sdio_host_oe(link.sdio_host_oe),
    .sdio_dev_o(link.sdio_dev_o), .sdio_dev_oe(link.sdio_dev_oe),
    .sdo_dev_o(link.sdo_dev_o), .sdo_dev_oe(link.sdo_dev_oe),
    .config_serial_data_io(link.config_serial_data_io),
    .sdo_line(link.sdo_line));

  task automatic stop_test;
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic want);
    cmp8({7'h00, got}, {7'h00, want});
  endtask : cmp1

  // own checksum model, kept apart from the design's function
  function automatic logic [7:0] ref_crc(input logic [7:0] d);
    logic [7:0] c;
    c = 8'ha5;
    for (int i = 7; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : ref_crc

  // one command, held until taken, then wait for its answer
  task automatic xfer(input logic rd, input logic [14:0] a,
    input logic [7:0] d, input logic last);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_last = last;
    for (int n = 0; n < 64; n++)
    begin
      @(posedge ref_clk);
      if (cmd_ready === 1'b1)
        break;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (int n = 0; n < 2000; n++)
    begin
      @(posedge ref_clk);
      if (rsp_valid === 1'b1)
        break;
    end
  endtask : xfer

  task automatic wr(input logic [14:0] a, input logic [7:0] d,
    input logic last);
    exp_q.push_back({1'b0, 8'h00});
    xfer(1'b0, a, d, last);
  endtask : wr

  task automatic rd(input logic [14:0] a, input logic [7:0] want,
    input logic last);
    exp_q.push_back({1'b1, want});
    xfer(1'b1, a, 8'h00, last);
  endtask : rd

  // settings are only changed between frames
  task automatic idle;
    repeat (16) @(negedge ref_clk);
  endtask : idle

  // an answer with no note pending is forced to mismatch
  always @(posedge ref_clk)
    if (rsp_valid === 1'b1)
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : {1'b1, 8'hxx};
      if (e.rd)
        cmp8(rsp_rdata, e.data);
      cmp1(rsp_ok, 1'b1);
    end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    stop_test;
  end

  initial
  begin
    void'($urandom(32'h68e4ca13));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    r = 8'($urandom);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    cmp1(dev_stream, 1'b1);
    wr(setup_a_addr, 8'h20, 1'b1);
    wr(15'h00b7, d0, 1'b0);
    wr(15'h00b7, d1, 1'b0);
    wr(15'h00b7, d2, 1'b1);
    rd(15'h00b8, d1, 1'b0);
    rd(15'h00b8, d2, 1'b0);
    rd(15'h00b8, 8'h20, 1'b1);
    wr(setup_a_addr, 8'h10, 1'b1);
    idle;
    cmp1(dev_four, 1'b1);
    h_four = 1'b1;
    rd(setup_a_addr, 8'h10, 1'b0);
    rd(setup_a_addr, d2, 1'b1);
    wr(loop_setup_b_addr, 8'h04, 1'b1);
    wr(loop_setup_a_addr, 8'h02, 1'b1);
    rd(15'h00b9, d2, 1'b0);
    rd(15'h00b9, d1, 1'b0);
    rd(15'h00b9, d0, 1'b0);
    rd(15'h00b9, d2, 1'b1);
    rd(loop_setup_a_addr, 8'h02, 1'b1);
    wr(loop_setup_b_addr, 8'h00, 1'b1);
    rd(loop_setup_a_addr, 8'h00, 1'b1);
    wr(checksum_setup_addr, 8'h01, 1'b1);
    idle;
    h_crc = 1'b1;
    wr(15'h0050, r, 1'b1);
    rd(15'h0050, r, 1'b1);
    idle;
    // host checksum off: the bench supplies the checksum byte as data
    h_crc = 1'b0;
    wr(15'h0051, ~r, 1'b0);
    wr(15'h0051, ref_crc(~r), 1'b1);
    wr(15'h0050, d0, 1'b0);
    wr(15'h0050, ref_crc(d0) ^ 8'h01, 1'b1);
    idle;
    cmp1(crc_err, 1'b1);
    h_crc = 1'b1;
    rd(15'h0051, ~r, 1'b1);
    rd(15'h0050, r, 1'b1);
    wr(15'h00c0, 8'h5a, 1'b1);
    rd(15'h00c0, 8'h00, 1'b1);
    rd(link_status_addr, 8'h03, 1'b1);
    wr(link_status_addr, 8'h03, 1'b1);
    rd(link_status_addr, 8'h00, 1'b1);
    idle;
    cmp1(crc_err, 1'b0);
    wr(setup_b_addr, 8'h80, 1'b1);
    idle;
    cmp1(dev_stream, 1'b0);
    h_stream = 1'b0;
    h_four = 1'b0;
    wr(setup_a_addr, 8'h00, 1'b0);
    idle;
    wr(15'h0030, d1, 1'b0);
    rd(15'h00b7, d0, 1'b0);
    rd(15'h0030, d1, 1'b0);
    wr(15'h0031, d2, 1'b0);
    rd(15'h0031, d2, 1'b1);
    // soft reset bit restores every register except the link status flags, streaming style included
    wr(setup_a_addr, 8'h01, 1'b1);
    idle;
    cmp1(dev_stream, 1'b1);
    h_stream = 1'b1;
    h_crc = 1'b0;
    rd(15'h0031, 8'h00, 1'b1);
    idle;
    cmp8(8'(exp_q.size()), 8'h00);
    stop_test;
  end
endmodule : tb_config_spi_access_sequencer
